/* rtl/gpio_pin_group.sv */
`timescale 1ns/10ps
module gpio_pin_group (
  input  wire logic [7:0]           data,
  input  wire logic [7:0]           dir,
  input  wire logic [7:0]           own_mask,
  input  wire logic [7:0]           own_out,
  input  wire logic [7:0]           own_oe,
  input  wire logic [7:0]           pin_in,
  output gpio_share_pkg::pins_s     pins,
  output logic      [7:0]           rdata
);
  import gpio_share_pkg::*;

  // ----------------------------------------
  // pad drive and read-back
  // ----------------------------------------
  // owned pins follow their function; others follow data and direction
  always_comb begin
    pins.out = (own_mask & own_out) | (~own_mask & data);
    pins.oe  = (own_mask & own_oe) | (~own_mask & dir);
    // outputs read the latch, inputs and owned pins read the pad
    rdata    = (~own_mask & dir & data) | ((own_mask | ~dir) & pin_in);
  end

endmodule : gpio_pin_group

/* rtl/gpio_share_pkg.sv */
package gpio_share_pkg;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [5:0] IDX_PORT_A_DATA = 6'h00;
  localparam logic [5:0] IDX_PORT_B_DATA = 6'h01;
  localparam logic [5:0] IDX_PORT_C_DATA = 6'h02;
  localparam logic [5:0] IDX_PORT_D_DATA = 6'h03;
  localparam logic [5:0] IDX_PORT_A_DIR  = 6'h04;
  localparam logic [5:0] IDX_PORT_B_DIR  = 6'h05;
  localparam logic [5:0] IDX_PORT_C_DIR  = 6'h06;
  localparam logic [5:0] IDX_PORT_D_DIR  = 6'h07;
  localparam logic [5:0] IDX_SERIAL_CTRL = 6'h08;
  localparam logic [5:0] IDX_SERIAL_STAT = 6'h09;
  localparam logic [5:0] IDX_SERIAL_DATA = 6'h0A;
  localparam logic [5:0] IDX_CONV_CTRL   = 6'h0B;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int         SERIAL_ENABLE_POS = 6;
  localparam int         MASTER_SELECT_POS = 4;
  localparam int         COMPLETE_POS      = 7;
  localparam int         COLLISION_POS     = 6;
  localparam int         CONV_ON_POS       = 5;
  localparam int         SCK_POS           = 7;
  localparam int         SDI_POS           = 6;
  localparam int         SDO_POS           = 5;
  localparam int         CAPTURE_POS       = 7;
  localparam logic [7:0] SERIAL_PIN_MASK   = 8'hE0;
  localparam logic [7:0] ANALOG_PIN_MASK   = 8'hF8;
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [3:0] SCK_HALF_CYCLES   = 4'h2;

  // one pin group as seen from the pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pins_s;

  // analog channel n sits on port C bit 6-n
  function automatic logic [7:0] channel_mask(input logic [1:0] ch);
    channel_mask = 8'h40 >> ch;
  endfunction : channel_mask

endpackage : gpio_share_pkg

/* rtl/serial_shifter.sv */
`timescale 1ns/10ps
module serial_shifter (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       master,
  input  wire logic       start,
  input  wire logic [7:0] load_data,
  input  wire logic       sck_in,
  input  wire logic       sdi,
  output logic            sck_out,
  output logic            sdo,
  output logic [7:0]      shift_data,
  output logic            busy,
  output logic            done
);
  import gpio_share_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } shift_state_e;

  shift_state_e state_reg, state_next;
  logic [7:0]   shift_reg, shift_next;
  logic [2:0]   cnt_reg, cnt_next;
  logic [3:0]   div_reg, div_next;
  logic         sck_reg, sck_next;
  logic         sck_prev_reg;
  logic         done_reg, done_next;
  logic         rise;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // slave edges come from the pad, master edges from the divider
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    div_next   = div_reg;
    sck_next   = sck_reg;
    done_next  = 1'b0;
    rise       = 1'b0;
    if (!master) begin
      rise = sck_in & ~sck_prev_reg;
    end else if (state_reg == ST_RUN || sck_reg) begin
      div_next = div_reg + 4'h1;
      if (div_reg == SCK_HALF_CYCLES - 4'h1) begin
        div_next = 4'h0;
        sck_next = ~sck_reg;
        rise     = ~sck_reg;
      end
    end
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          shift_next = load_data;
          cnt_next   = 3'h0;
          div_next   = 4'h0;
          sck_next   = 1'b0;
          state_next = ST_RUN;
        end else if (rise) begin
          // slave transfer opened by the far master's first edge
          shift_next = {shift_reg[6:0], sdi};
          cnt_next   = 3'h1;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rise) begin
          shift_next = {shift_reg[6:0], sdi};
          cnt_next   = cnt_reg + 3'h1;
          if (cnt_reg == 3'h7) begin
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // disabling aborts and resets the bit counter
    if (!enable) begin
      state_next = ST_IDLE;
      cnt_next   = 3'h0;
      div_next   = 4'h0;
      sck_next   = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_IDLE;
      shift_reg    <= REG_RESET;
      cnt_reg      <= 3'h0;
      div_reg      <= 4'h0;
      sck_reg      <= 1'b0;
      sck_prev_reg <= 1'b0;
      done_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      cnt_reg      <= cnt_next;
      div_reg      <= div_next;
      sck_reg      <= sck_next;
      sck_prev_reg <= sck_in;
      done_reg     <= done_next;
    end
  end

  assign sck_out    = sck_reg;
  assign sdo        = shift_reg[7];
  assign shift_data = shift_reg;
  assign busy       = (state_reg == ST_RUN);
  assign done       = done_reg;

endmodule : serial_shifter

/* rtl/shared_function_io_ports.sv */
`timescale 1ns/10ps
// Summary of operation
// - Reset clears all four direction registers asynchronously, without needing a clock.
// - The capture pin is always an input and the compare pin always an output.
// - Port C is an 8-bit general port whose five shared pins are plain I/O when the converter is off.
// - With the converter on, C7 is its high reference and C6..C3 are channels selected by software.
// - With the converter on, C7..C3 never drive; only C2..C0 may be outputs.
// - With the converter on, the selected channel bit reads zero in port C data.
// - The port B direction register sits at index 0x05 and steers port B pins.
// - Serial enable (control bit 6) gives B7..B5 to the serial port; clearing returns them.
// - In master mode B7 drives the serial clock, B6 is data in and B5 is data out.
// - In master mode a data write while idle loads the shifter and starts a transfer.
// - In slave mode the B7 clock pin is an input; data pins keep their roles.
// - Setting serial enable loads B direction bits; clearing it leaves them.
module shared_function_io_ports (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [7:0]            port_a_in,
  output gpio_share_pkg::pins_s      port_a_pins,
  input  wire logic [7:0]            port_b_in,
  output gpio_share_pkg::pins_s      port_b_pins,
  input  wire logic [7:0]            port_c_in,
  output gpio_share_pkg::pins_s      port_c_pins,
  input  wire logic [7:0]            port_d_in,
  output gpio_share_pkg::pins_s      port_d_pins,
  input  wire logic                  compare_level,
  output logic                       compare_output_pin,
  output logic                       converter_on,
  output logic      [1:0]            converter_channel
);
  import gpio_share_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]  data_reg [0:3];
  logic [7:0]  data_next [0:3];
  logic [7:0]  dir_reg [0:3];
  logic [7:0]  dir_next [0:3];
  logic [7:0]  sctrl_reg, sctrl_next;
  logic [7:0]  conv_reg, conv_next;
  logic        complete_reg, complete_next;
  logic        collision_reg, collision_next;
  logic        armed_reg, armed_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        err_reg, err_next;
  logic        compare_reg;

  logic [7:0]  rd_port [0:3];
  logic [7:0]  own_mask [0:3];
  logic [7:0]  own_out [0:3];
  logic [7:0]  own_oe [0:3];
  logic [7:0]  port_in [0:3];
  pins_s       pins [0:3];
  logic [5:0]  idx;
  logic        setup, access, wr, rd;
  logic        ser_en, ser_master, start;
  logic        sck_out, sdo, busy, done;
  logic [7:0]  shift_data;
  logic [7:0]  c_read;

  assign idx        = paddr[7:2];
  assign setup      = psel & ~penable;
  assign access     = psel & penable;
  assign wr         = access & pwrite & ~err_reg;
  assign rd         = access & ~pwrite & ~err_reg;
  assign ser_en     = sctrl_reg[SERIAL_ENABLE_POS];
  assign ser_master = sctrl_reg[MASTER_SELECT_POS];
  assign port_in[0] = port_a_in;
  assign port_in[1] = port_b_in;
  assign port_in[2] = port_c_in;
  assign port_in[3] = port_d_in;

  // ----------------------------------------
  // function ownership of pins
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      own_mask[i] = 8'h00;
      own_out[i]  = 8'h00;
      own_oe[i]   = 8'h00;
    end
    if (ser_en) begin
      own_mask[1] = SERIAL_PIN_MASK;
      own_out[1][SCK_POS] = sck_out;
      own_out[1][SDO_POS] = sdo;
      own_oe[1][SCK_POS]  = ser_master;
      // data out may still be floated via its direction bit
      own_oe[1][SDO_POS]  = dir_reg[1][SDO_POS];
    end
    if (conv_reg[CONV_ON_POS]) begin
      own_mask[2] = ANALOG_PIN_MASK;
    end
    own_mask[3][CAPTURE_POS] = 1'b1;
  end

  // ----------------------------------------
  // pin groups
  // ----------------------------------------
  // function overrides data and direction
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_port
      gpio_pin_group u_group (
        .data     (data_reg[g]),
        .dir      (dir_reg[g]),
        .own_mask (own_mask[g]),
        .own_out  (own_out[g]),
        .own_oe   (own_oe[g]),
        .pin_in   (port_in[g]),
        .pins     (pins[g]),
        .rdata    (rd_port[g])
      );
    end
  endgenerate

  assign port_a_pins = pins[0];
  assign port_b_pins = pins[1];
  assign port_c_pins = pins[2];
  assign port_d_pins = pins[3];

  assign c_read = conv_reg[CONV_ON_POS] ?
                  (rd_port[2] & ~channel_mask(conv_reg[1:0])) : rd_port[2];

  // ----------------------------------------
  // serial shifter
  // ----------------------------------------
  // data write starts master transfer
  assign start = wr & (idx == IDX_SERIAL_DATA) & ser_en & ser_master & ~busy;

  serial_shifter u_shifter (
    .pclk       (pclk),
    .presetn    (presetn),
    .enable     (ser_en),
    .master     (ser_master),
    .start      (start),
    .load_data  (pwdata[7:0]),
    .sck_in     (port_b_in[SCK_POS]),
    .sdi        (port_b_in[SDI_POS]),
    .sck_out    (sck_out),
    .sdo        (sdo),
    .shift_data (shift_data),
    .busy       (busy),
    .done       (done)
  );

  // ----------------------------------------
  // register writes and flags
  // ----------------------------------------
  // software writes to C7..C3 while converting are accepted; caller beware
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      data_next[i] = data_reg[i];
      dir_next[i]  = dir_reg[i];
    end
    sctrl_next     = sctrl_reg;
    conv_next      = conv_reg;
    complete_next  = complete_reg;
    collision_next = collision_reg;
    armed_next     = armed_reg;
    if (wr) begin
      case (idx)
        IDX_PORT_A_DATA, IDX_PORT_B_DATA,
        IDX_PORT_C_DATA, IDX_PORT_D_DATA: data_next[idx[1:0]] = pwdata[7:0];
        // port B direction at index 5
        IDX_PORT_A_DIR, IDX_PORT_B_DIR,
        IDX_PORT_C_DIR, IDX_PORT_D_DIR: dir_next[idx[1:0]] = pwdata[7:0];
        IDX_SERIAL_CTRL: begin
          sctrl_next = pwdata[7:0] &
                       ((8'h01 << SERIAL_ENABLE_POS) | (8'h01 << MASTER_SELECT_POS));
          if (pwdata[SERIAL_ENABLE_POS] && !ser_en) begin
            dir_next[1][SCK_POS] = pwdata[MASTER_SELECT_POS];
            dir_next[1][SDI_POS] = 1'b0;
            dir_next[1][SDO_POS] = 1'b1;
          end
          // disabling is the way out of a collision with no completion
          if (!pwdata[SERIAL_ENABLE_POS]) begin
            collision_next = 1'b0;
            armed_next     = 1'b0;
          end
        end
        IDX_CONV_CTRL: conv_next = pwdata[7:0] & 8'h23;
        default: ;
      endcase
    end
    // status read while complete arms the clearing sequence
    if (rd && idx == IDX_SERIAL_STAT && complete_reg) begin
      armed_next = 1'b1;
    end
    if (access && !err_reg && idx == IDX_SERIAL_DATA) begin
      if (armed_reg) begin
        complete_next  = 1'b0;
        collision_next = 1'b0;
        armed_next     = 1'b0;
      end
      if (busy) begin
        collision_next = 1'b1;
      end
    end
    // a completion in the clearing cycle wins over the clear
    if (done) begin
      complete_next = 1'b1;
    end
  end

  // ----------------------------------------
  // read path, taken in the setup phase
  // ----------------------------------------
  // reading during setup keeps prdata on a flop with no wait state
  always_comb begin
    prdata_next = prdata_reg;
    err_next    = err_reg;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      err_next    = 1'b0;
      case (idx)
        IDX_PORT_A_DATA: prdata_next[7:0] = rd_port[0];
        IDX_PORT_B_DATA: prdata_next[7:0] = rd_port[1];
        IDX_PORT_C_DATA: prdata_next[7:0] = c_read;
        IDX_PORT_D_DATA: prdata_next[7:0] = rd_port[3];
        IDX_PORT_A_DIR, IDX_PORT_B_DIR,
        IDX_PORT_C_DIR, IDX_PORT_D_DIR: prdata_next[7:0] = dir_reg[idx[1:0]];
        IDX_SERIAL_CTRL: prdata_next[7:0] = sctrl_reg;
        IDX_SERIAL_STAT: begin
          prdata_next[COMPLETE_POS]  = complete_reg;
          prdata_next[COLLISION_POS] = collision_reg;
        end
        IDX_SERIAL_DATA: prdata_next[7:0] = shift_data;
        IDX_CONV_CTRL:   prdata_next[7:0] = conv_reg;
        default:         err_next = 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // async clear of directions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        data_reg[i] <= REG_RESET;
        dir_reg[i]  <= REG_RESET;
      end
      sctrl_reg     <= REG_RESET;
      conv_reg      <= REG_RESET;
      complete_reg  <= 1'b0;
      collision_reg <= 1'b0;
      armed_reg     <= 1'b0;
      prdata_reg    <= 32'h0000_0000;
      err_reg       <= 1'b0;
      compare_reg   <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        data_reg[i] <= data_next[i];
        dir_reg[i]  <= dir_next[i];
      end
      sctrl_reg     <= sctrl_next;
      conv_reg      <= conv_next;
      complete_reg  <= complete_next;
      collision_reg <= collision_next;
      armed_reg     <= armed_next;
      prdata_reg    <= prdata_next;
      err_reg       <= err_next;
      compare_reg   <= compare_level;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // compare pin output only
  assign compare_output_pin = compare_reg;
  assign converter_on       = conv_reg[CONV_ON_POS];
  assign converter_channel  = conv_reg[1:0];
  assign prdata             = prdata_reg;
  assign pready             = 1'b1;
  assign pslverr            = access & err_reg;

endmodule : shared_function_io_ports

/* tb/io_ports_monitor.sv */
`timescale 1ns/10ps
module io_ports_monitor
  import gpio_share_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire gpio_share_pkg::pins_s port_a_pins,
  input wire gpio_share_pkg::pins_s port_b_pins,
  input wire gpio_share_pkg::pins_s port_c_pins,
  input wire gpio_share_pkg::pins_s port_d_pins,
  input wire logic                  compare_level,
  input wire logic                  compare_output_pin,
  input wire logic                  converter_on,
  input wire logic [1:0]            converter_channel
);
  logic [5:0] idx;
  logic       acc, wr, live_reg;
  logic [7:0] ctl_reg, ctl_next;

  // ----------------------------------------
  // serial control shadow
  // ----------------------------------------
  assign idx = paddr[7:2];
  assign acc = psel & penable;
  assign wr  = acc & pwrite;

  // shadow takes completed writes
  always_comb begin
    ctl_next = ctl_reg;
    if (wr && idx == IDX_SERIAL_CTRL) ctl_next = pwdata[7:0];
  end

  // live_reg masks the first edge after reset for $past
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg  <= 8'h00;
      live_reg <= 1'b0;
    end else begin
      ctl_reg  <= ctl_next;
      live_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load;
    wr && idx == IDX_SERIAL_DATA && ctl_reg[SERIAL_ENABLE_POS] && ctl_reg[MASTER_SELECT_POS];
  endsequence
  sequence s_sck_rise;
    $rose(port_b_pins.out[SCK_POS]);
  endsequence

  property p_reset_dirs;
    $rose(presetn) |-> {port_a_pins.oe, port_b_pins.oe, port_c_pins.oe, port_d_pins.oe} == 32'h0;
  endproperty
  property p_compare;
    live_reg |-> compare_output_pin == $past(compare_level);
  endproperty
  property p_capture;
    port_d_pins.oe[CAPTURE_POS] == 1'b0;
  endproperty
  property p_c_dir;
    wr && idx == IDX_PORT_C_DIR && !converter_on |=> port_c_pins.oe == $past(pwdata[7:0]);
  endproperty
  property p_conv_oe;
    converter_on |-> (port_c_pins.oe & ANALOG_PIN_MASK) == 8'h00;
  endproperty
  property p_chan_zero;
    live_reg && acc && !pwrite && idx == IDX_PORT_C_DATA && $past(converter_on)
      |-> prdata[3'd6 - $past(converter_channel)] == 1'b0;
  endproperty
  property p_b_dir;
    wr && idx == IDX_PORT_B_DIR && !ctl_reg[SERIAL_ENABLE_POS]
      |=> port_b_pins.oe == $past(pwdata[7:0]);
  endproperty
  property p_serial_roles;
    ctl_reg[SERIAL_ENABLE_POS] |-> port_b_pins.oe[SCK_POS] == ctl_reg[MASTER_SELECT_POS]
      && port_b_pins.oe[SDI_POS] == 1'b0;
  endproperty
  property p_start;
    s_load |-> ##[1:4] s_sck_rise;
  endproperty

  a_reset_dirs:   assert property (p_reset_dirs)   else $error("dirs not clear");
  a_compare:      assert property (p_compare)      else $error("compare pin");
  a_capture:      assert property (p_capture)      else $error("capture drives");
  a_c_dir:        assert property (p_c_dir)        else $error("port c oe");
  a_conv_oe:      assert property (p_conv_oe)      else $error("analog pin drives");
  a_chan_zero:    assert property (p_chan_zero)    else $error("channel bit set");
  a_b_dir:        assert property (p_b_dir)        else $error("port b oe");
  a_serial_roles: assert property (p_serial_roles) else $error("serial pin roles");
  a_start:        assert property (p_start)        else $error("no transfer start");
endmodule : io_ports_monitor

bind shared_function_io_ports io_ports_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
  .port_c_pins(port_c_pins), .port_d_pins(port_d_pins),
  .compare_level(compare_level), .compare_output_pin(compare_output_pin),
  .converter_on(converter_on), .converter_channel(converter_channel)
);

/* tb/pad_partner.sv */
`timescale 1ns/10ps
module pad_partner
  import gpio_share_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire gpio_share_pkg::pins_s port_a_pins,
  input  wire gpio_share_pkg::pins_s port_b_pins,
  input  wire gpio_share_pkg::pins_s port_c_pins,
  input  wire gpio_share_pkg::pins_s port_d_pins,
  input  wire logic [31:0]           ext,
  input  wire logic [7:0]            tx_byte,
  input  wire logic                  tx_load,
  output logic      [7:0]            port_a_in,
  output logic      [7:0]            port_b_in,
  output logic      [7:0]            port_c_in,
  output logic      [7:0]            port_d_in,
  output logic      [7:0]            rx
);
  logic [7:0] tx_reg;
  logic       sck, sck_d, sdo_d;

  // released pads take the far-side level, driven pads echo the device
  assign sck       = port_b_pins.out[SCK_POS] & port_b_pins.oe[SCK_POS];
  assign port_a_in = (port_a_pins.out & port_a_pins.oe) | (ext[7:0] & ~port_a_pins.oe);
  assign port_b_in = (port_b_pins.out & port_b_pins.oe)
                   | ({ext[15], tx_reg[7], ext[13:8]} & ~port_b_pins.oe);
  assign port_c_in = (port_c_pins.out & port_c_pins.oe) | (ext[23:16] & ~port_c_pins.oe);
  assign port_d_in = (port_d_pins.out & port_d_pins.oe) | (ext[31:24] & ~port_d_pins.oe);

  // slave end, msb first
  // data out is latched while the clock is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= 8'h00;
      sck_d  <= 1'b0;
      sdo_d  <= 1'b0;
      rx     <= 8'h00;
    end else begin
      sck_d <= sck;
      if (!sck) sdo_d <= port_b_pins.out[SDO_POS];
      if (tx_load) tx_reg <= tx_byte;
      else if (!sck && sck_d) tx_reg <= {tx_reg[6:0], tx_reg[7]};
      if (sck && !sck_d) rx <= {rx[6:0], sdo_d};
    end
  end
endmodule : pad_partner

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
  import gpio_share_pkg::*;
  logic        pclk = 1'b0, run = 1'b1, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, cmp_lvl = 1'b0, tx_load = 1'b0, slv;
  logic        pready, pslverr, cmp_pin, conv_on;
  logic [7:0]  paddr = 8'h00, tx_byte = 8'h00, pa, pb, pc, pd, rx, dd, dv;
  logic [31:0] pwdata = 32'h0, ext = 32'h0, seed = 32'h4AD27607, prdata, rd;
  logic [1:0]  conv_ch;
  pins_s       pa_p, pb_p, pc_p, pd_p;
  pins_s       pp [3];
  logic [7:0]  pads [3];
  int          err_total = 0, compares = 0, cyc = 0, n;

  assign pp   = '{pa_p, pb_p, pc_p};
  assign pads = '{pa, pb, pc};

  // ----------------------------------------
  // clock, timeout and timer level
  // ----------------------------------------
  always #50 if (run) pclk = ~pclk;

  // ceiling far above the run's length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    cmp_lvl <= seed[cyc % 32];
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  shared_function_io_ports dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_in(pa), .port_a_pins(pa_p), .port_b_in(pb), .port_b_pins(pb_p),
    .port_c_in(pc), .port_c_pins(pc_p), .port_d_in(pd), .port_d_pins(pd_p),
    .compare_level(cmp_lvl), .compare_output_pin(cmp_pin),
    .converter_on(conv_on), .converter_channel(conv_ch)
  );

  pad_partner far (
    .pclk(pclk), .presetn(presetn), .port_a_pins(pa_p), .port_b_pins(pb_p),
    .port_c_pins(pc_p), .port_d_pins(pd_p), .ext(ext), .tx_byte(tx_byte),
    .tx_load(tx_load), .port_a_in(pa), .port_b_in(pb), .port_c_in(pc),
    .port_d_in(pd), .rx(rx)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // output bits read the latch, input bits the pad
  function automatic logic [31:0] pin_rd(input logic [7:0] v, input logic [7:0] dr,
                                         input logic [7:0] pad);
    return {24'h0, (v & dr) | (pad & ~dr)};
  endfunction : pin_rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int k = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    rd = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic summarize;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 4; p < 8; p++) begin
      apb(1'b0, 6'(p), 8'h00);
      chk(rd, 32'h0);
    end
    chk({pa_p.oe, pb_p.oe, pc_p.oe, pd_p.oe}, 32'h0);
    seed = xs(seed);
    ext <= seed;
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      dd = seed[7:0];
      dv = seed[15:8];
      apb(1'b1, 6'(k % 3 + 4), dd);
      apb(1'b1, 6'(k % 3), dv);
      apb(1'b0, 6'(k % 3 + 4), 8'h00);
      chk(rd, {24'h0, dd});
      apb(1'b0, 6'(k % 3), 8'h00);
      chk(rd, pin_rd(dv, dd, pads[k % 3]));
      chk({24'h0, pp[k % 3].oe}, {24'h0, dd});
    end
    apb(1'b1, IDX_PORT_D_DIR, 8'hFF);
    @(negedge pclk);
    chk({24'h0, pd_p.oe}, 32'h7F);
    apb(1'b0, 6'h3F, 8'h00);
    chk({rd[30:0], slv}, 32'h1);
    apb(1'b1, IDX_PORT_C_DIR, 8'hFF);
    apb(1'b1, IDX_PORT_C_DATA, 8'h5A);
    for (int ch = 0; ch < 4; ch++) begin
      apb(1'b1, IDX_CONV_CTRL, 8'h20 | 8'(ch));
      apb(1'b0, IDX_PORT_C_DATA, 8'h00);
      chk(rd, pin_rd(8'h5A, 8'h07, pc) & ~(32'h40 >> ch));
      chk({24'h0, pc_p.oe}, 32'h07);
      chk({29'h0, conv_on, conv_ch}, 32'(4 + ch));
    end
    apb(1'b1, IDX_CONV_CTRL, 8'h00);
    @(negedge pclk);
    chk({24'h0, pc_p.oe}, 32'hFF);
    // enabling serial as master loads the port b directions
    apb(1'b1, IDX_PORT_B_DIR, 8'h00);
    apb(1'b1, IDX_SERIAL_CTRL, 8'h50);
    apb(1'b0, IDX_PORT_B_DIR, 8'h00);
    chk(rd, 32'hA0);
    seed = xs(seed);
    tx_byte <= seed[7:0];
    tx_load <= 1'b1;
    @(posedge pclk);
    tx_load <= 1'b0;
    apb(1'b1, IDX_SERIAL_DATA, seed[15:8]);
    n = 0;
    rd = 32'h0;
    while (rd[COMPLETE_POS] !== 1'b1 && n < 40) begin
      apb(1'b0, IDX_SERIAL_STAT, 8'h00);
      n++;
    end
    chk({24'h0, rx}, {24'h0, seed[15:8]});
    apb(1'b0, IDX_SERIAL_DATA, 8'h00);
    chk(rd, {24'h0, seed[7:0]});
    apb(1'b1, IDX_SERIAL_CTRL, 8'h00);
    @(negedge pclk);
    chk({24'h0, pb_p.oe}, 32'hA0);
    apb(1'b1, IDX_SERIAL_CTRL, 8'h40);
    apb(1'b0, IDX_PORT_B_DIR, 8'h00);
    chk(rd, 32'h20);
    chk({24'h0, pb_p.oe}, 32'h20);
    // mid-transfer abort; off first, so enabling reloads the directions
    apb(1'b1, IDX_SERIAL_CTRL, 8'h00);
    apb(1'b1, IDX_SERIAL_CTRL, 8'h50);
    apb(1'b1, IDX_SERIAL_DATA, 8'hC3);
    apb(1'b1, IDX_SERIAL_CTRL, 8'h00);
    @(negedge pclk);
    chk({24'h0, pb_p.oe}, 32'hA0);
    apb(1'b1, IDX_PORT_A_DIR, 8'hFF);
    @(negedge pclk);
    run = 1'b0;
    presetn = 1'b0;
    #225;
    chk({24'h0, pa_p.oe}, 32'h0);
    presetn = 1'b1;
    run = 1'b1;
    apb(1'b0, IDX_PORT_A_DIR, 8'h00);
    chk(rd, 32'h0);
    summarize();
  end
endmodule : tb
